/* logic/dsssdm_demod.sv */
// Receive data path: DPSK demodulation, quality, SFD timer, descrambling
//
// What this block and its software must do
// RQ1: Average 16 phase errors, report variance
// RQ2: Differential first, coherent once loop tracks
// RQ3: Integrate quality over 128-symbol blocks
// RQ4: Data thresholds stored apart from acquisition
// RQ5: Drop on low amplitude or high noise
// RQ6: Programmable SFD timer returns to acquisition
// RQ7: Software sets timeout preamble plus 16
// RQ8: Software may set thresholds to limits
// RQ9: Map phase change to Gray dibit
// RQ10: Binary modes use dibits 00, 11
// RQ11: Counterclockwise unless invert bit set
// RQ12: Seven-bit self-synchronizing shift register
// RQ13: Descrambling can be disabled
// RQ14: Output is data XOR enabled taps
// RQ15: Seed and taps in separate registers
// RQ16: Tolerate 25 ppm clock offset per end
// RQ17: Seven symbols seed descrambler first
// RQ18: Thresholds are high and low bytes
// RQ19: Decide at block end, then clear
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module dsssdm_demod (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Symbols from the tracked correlator
  input wire logic i_sym_valid,
  input wire logic [7:0] i_sym_phase,
  input wire logic [15:0] i_sym_amp,
  input wire logic [7:0] i_nco_phase,
  input wire logic i_pll_lock,
  input wire logic i_qpsk,
  // Sequencing
  input wire logic i_acq_done,
  input wire logic i_sfd_found,
  // Carrier loop feedback
  output logic [7:0] o_freq_corr,
  output logic o_freq_valid,
  output logic [15:0] o_sq_var,
  // Received data to the network processor
  output logic o_rx_valid,
  output logic o_rx_two,
  output logic [1:0] o_rx_bits,
  // Status
  output logic o_coherent,
  output logic o_drop_lock,
  output dsssdm_pkg::dsssdm_state_e o_state,
  // Transmit scrambler settings
  output logic [6:0] o_tx_seed,
  output logic [6:0] o_scr_tap,
  output logic o_scr_en
);
  import dsssdm_pkg::*;
  dsssdm_state_e state_r;
  logic [7:0] test_b_r, seed_r, tap_r, ctrl_r, timeout_r;
  logic [7:0] amp_hi_r, amp_lo_r, ph_hi_r, ph_lo_r;
  logic [7:0] rdata_nxt, tmr_r, prev_ph_r;
  logic rd_err_nxt, wr_en, have_prev_r, sq_drop, seeded, expire;
  logic [7:0] ref_ph, dph, q_off, b_off, perr;
  logic [1:0] quad, quad_s, dibit;
  logic bin;
  logic [15:0] perr_sq, avg_amp, avg_pn, msq;
  logic [11:0] sum_e_r, sum_e_nxt;
  logic [16:0] sum_e2_r, sum_e2_nxt;
  logic [3:0] fcnt_r;
  logic [7:0] mean;
  logic sym_ok;

  // Gray mapping of quadrant steps to dibits
  function automatic logic [1:0] quad_map(input logic [1:0] q);
    unique case (q)
      2'd0: quad_map = 2'b00;
      2'd1: quad_map = 2'b01;
      2'd2: quad_map = 2'b11;
      2'd3: quad_map = 2'b10;
    endcase
  endfunction

  // Register read decode; status and unmapped reads are handled here
  always_comb begin
    rdata_nxt = 8'h00;
    rd_err_nxt = 1'b0;
    unique case (i_paddr)
      OFS_TEST_B: rdata_nxt = test_b_r;
      OFS_SEED: rdata_nxt = seed_r;
      OFS_TAP: rdata_nxt = tap_r;
      OFS_AMP_HI: rdata_nxt = amp_hi_r;
      OFS_AMP_LO: rdata_nxt = amp_lo_r;
      OFS_PH_HI: rdata_nxt = ph_hi_r;
      OFS_PH_LO: rdata_nxt = ph_lo_r;
      OFS_TIMEOUT: rdata_nxt = timeout_r;
      OFS_CTRL: rdata_nxt = ctrl_r;
      OFS_STATUS: rdata_nxt = {4'h0, seeded, o_coherent, state_r};
      default: rd_err_nxt = 1'b1;
    endcase
  end

  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && !rd_err_nxt;

  // APB answer: data latched in setup, ready for the first access cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      if (i_psel && !i_penable) begin
        o_prdata <= {24'h000000, rdata_nxt};
        o_pslverr <= rd_err_nxt;
      end
    end
  end

  // Configuration registers; data thresholds live apart from acquisition ones
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      test_b_r <= RST_TEST_B;
      seed_r <= RST_SEED;
      tap_r <= RST_TAP;
      amp_hi_r <= RST_AMP_HI;
      amp_lo_r <= RST_AMP_LO;
      ph_hi_r <= RST_PH_HI;
      ph_lo_r <= RST_PH_LO;
      timeout_r <= RST_TIMEOUT;
      ctrl_r <= RST_CTRL;
    end else if (wr_en) begin
      unique case (i_paddr)
        OFS_TEST_B: test_b_r <= i_pwdata[7:0];
        OFS_SEED: seed_r <= i_pwdata[7:0]; // see RQ15
        OFS_TAP: tap_r <= i_pwdata[7:0]; // see RQ15
        OFS_AMP_HI: amp_hi_r <= i_pwdata[7:0]; // see RQ4
        OFS_AMP_LO: amp_lo_r <= i_pwdata[7:0];
        OFS_PH_HI: ph_hi_r <= i_pwdata[7:0];
        OFS_PH_LO: ph_lo_r <= i_pwdata[7:0];
        OFS_TIMEOUT: timeout_r <= i_pwdata[7:0];
        OFS_CTRL: ctrl_r <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Phase change per symbol; 8-bit wrap keeps slow clock drift harmless
  always_comb begin
    ref_ph = o_coherent ? i_sym_phase - i_nco_phase : i_sym_phase; // see RQ2
    dph = ref_ph - prev_ph_r; // see RQ16
    q_off = dph + QUAD_HALF;
    b_off = dph + BIN_HALF;
    quad = q_off[7:6];
    bin = b_off[7];
    quad_s = test_b_r[ROT_INV_BIT] ? 2'(2'd0 - quad) : quad; // see RQ11
    dibit = i_qpsk ? quad_map(quad_s) : {bin, bin}; // see RQ9 see RQ10
    perr = i_qpsk ? dph - {quad, 6'h00} : dph - {bin, 7'h00};
    perr_sq = 16'($signed(perr) * $signed(perr));
  end

  assign sym_ok = i_sym_valid && have_prev_r;

  // Reference phase of the previous symbol
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prev_ph_r <= 8'h00;
      have_prev_r <= 1'b0;
    end else if (i_sym_valid) begin
      prev_ph_r <= ref_ph;
      have_prev_r <= 1'b1;
    end
  end

  // Coherent detection follows the carrier loop while a signal is held
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_coherent <= 1'b0;
    end else begin
      o_coherent <= i_pll_lock && state_r != ST_ACQ && !o_drop_lock; // see RQ2
    end
  end

  // Sixteen-symbol mean and spread of the phase error
  always_comb begin
    sum_e_nxt = sum_e_r + {{4{perr[7]}}, perr};
    // Squared error reaches 4096 in binary mode; cutting it would hide real noise
    sum_e2_nxt = sum_e2_r + {4'h0, perr_sq[12:0]};
    mean = sum_e_nxt[11:FREQ_SHIFT];
    msq = 16'($signed(mean) * $signed(mean));
  end

  // The variance is mean square less squared mean; a floored negative mean can make it wrap below zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sum_e_r <= 12'h000;
      sum_e2_r <= 17'h00000;
      fcnt_r <= 4'h0;
      o_freq_corr <= 8'h00;
      o_freq_valid <= 1'b0;
      o_sq_var <= 16'h0000;
    end else begin
      o_freq_valid <= 1'b0;
      if (sym_ok) begin
        fcnt_r <= fcnt_r + 4'h1;
        if (fcnt_r == FREQ_LAST) begin
          sum_e_r <= 12'h000;
          sum_e2_r <= 17'h00000;
          o_freq_corr <= mean; // see RQ1
          o_freq_valid <= 1'b1;
          o_sq_var <= {3'h0, sum_e2_nxt[16:FREQ_SHIFT]} - msq; // see RQ1
        end else begin
          sum_e_r <= sum_e_nxt;
          sum_e2_r <= sum_e2_nxt;
        end
      end
    end
  end

  // Delimiter search runs out after the programmed number of symbols
  assign expire = state_r == ST_SFD && tmr_r >= timeout_r && !i_sfd_found; // see RQ6

  // Receive sequencing and the drop-lock pulse
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= ST_ACQ;
      tmr_r <= 8'h00;
      o_drop_lock <= 1'b0;
    end else begin
      o_drop_lock <= 1'b0;
      unique case (state_r)
        ST_ACQ: begin
          tmr_r <= 8'h00;
          if (i_acq_done) begin
            state_r <= ST_SFD;
          end
        end
        ST_SFD: begin
          if (i_sym_valid) begin
            tmr_r <= tmr_r + 8'h01;
          end
          if (i_sfd_found) begin
            state_r <= ST_DATA;
          end else if (expire || sq_drop) begin
            state_r <= ST_ACQ; // see RQ6
            o_drop_lock <= 1'b1;
          end
        end
        ST_DATA: begin
          if (sq_drop) begin
            state_r <= ST_ACQ; // see RQ5
            o_drop_lock <= 1'b1;
          end
        end
        // Unused code falls back to acquisition
        default: begin
          state_r <= ST_ACQ;
        end
      endcase
    end
  end

  // Quality monitor; thresholds are joined from their high and low bytes
  dsssdm_sq u_sq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(state_r != ST_ACQ),
    .i_valid(sym_ok),
    .i_amp(i_sym_amp),
    .i_perr2(perr_sq[12:0]),
    .i_amp_thr({amp_hi_r, amp_lo_r}), // see RQ18
    .i_ph_thr({ph_hi_r, ph_lo_r}), // see RQ18
    .o_drop(sq_drop),
    .o_avg_amp(avg_amp),
    .o_avg_pn(avg_pn)
  );

  // Descrambler restarts its seeding at each new acquisition
  dsssdm_descr u_descr (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(state_r == ST_ACQ),
    .i_en(ctrl_r[CTRL_DESCR_EN_BIT]), // see RQ13
    .i_tap(tap_r[6:0]),
    .i_valid(sym_ok && state_r != ST_ACQ),
    .i_two(i_qpsk),
    .i_bits(dibit),
    .o_valid(o_rx_valid),
    .o_two(o_rx_two),
    .o_bits(o_rx_bits),
    .o_seeded(seeded)
  );

  // Mirrors for the outside world
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_state <= ST_ACQ;
      o_tx_seed <= 7'h00;
      o_scr_tap <= 7'h00;
      o_scr_en <= 1'b0;
    end else begin
      o_state <= state_r;
      o_tx_seed <= seed_r[6:0];
      o_scr_tap <= tap_r[6:0];
      o_scr_en <= ctrl_r[CTRL_DESCR_EN_BIT];
    end
  end

  a_timeout_drops: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ6
    expire |=> (state_r == ST_ACQ && o_drop_lock))
    else $error("search timeout did not return to acquisition");
  a_sfd_enters_data: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ6
    (state_r == ST_SFD && i_sfd_found) |=> state_r == ST_DATA)
    else $error("delimiter did not enter data mode");
  a_coherent_needs_lock: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ2
    o_coherent |-> ($past(i_pll_lock) && $past(state_r) != ST_ACQ))
    else $error("coherent mode without carrier lock");
  a_freq_every_16: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ1
    o_freq_valid |-> (fcnt_r == 4'h0 && $past(sym_ok)))
    else $error("frequency update off its 16 symbol block");
  a_bpsk_dibits: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ10
    !i_qpsk |-> dibit[0] == dibit[1])
    else $error("binary mode produced a quadrature dibit");
  a_apb_one_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_psel && !i_penable) |=> o_pready ##1 !o_pready)
    else $error("apb ready not a single access cycle");
endmodule

/* logic/dsssdm_descr.sv */
// Self-synchronizing 7-bit descrambler with seeding count
`timescale 1ns/1ps
module dsssdm_descr (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_clear,
  input wire logic i_en,
  input wire logic [6:0] i_tap,
  // Decoded symbol in
  input wire logic i_valid,
  input wire logic i_two,
  input wire logic [1:0] i_bits,
  // Data out
  output logic o_valid,
  output logic o_two,
  output logic [1:0] o_bits,
  output logic o_seeded
);
  import dsssdm_pkg::*;
  logic [6:0] sr_r;
  logic [2:0] seed_cnt_r;
  logic [6:0] sr_mid, sr_end;
  logic b0, b1;

  // One division step: quotient bit is data XOR the enabled taps
  function automatic logic dstep(input logic d, input logic [6:0] sr, input logic [6:0] tap);
    dstep = d ^ (^(sr & tap));
  endfunction

  // Low bit first; for two-bit symbols the register shifts twice
  always_comb begin
    b0 = i_en ? dstep(i_bits[0], sr_r, i_tap) : i_bits[0]; // see RQ14
    sr_mid = {sr_r[5:0], i_bits[0]}; // see RQ12
    b1 = i_en ? dstep(i_bits[1], sr_mid, i_tap) : i_bits[1];
    sr_end = i_two ? {sr_mid[5:0], i_bits[1]} : sr_mid;
  end

  // Shift register holds received (scrambled) bits, so it self-synchronizes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sr_r <= 7'h00;
    end else if (i_valid) begin
      sr_r <= sr_end;
    end
  end

  // Seeding: data stays hidden until the register is filled
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_clear) begin
      seed_cnt_r <= 3'h0;
    end else if (i_valid && seed_cnt_r != SEED_SYMS) begin
      seed_cnt_r <= seed_cnt_r + 3'h1; // see RQ17
    end
  end

  // Output stage
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_two <= 1'b0;
      o_bits <= 2'h0;
      o_seeded <= 1'b0;
    end else begin
      o_seeded <= !i_en || seed_cnt_r == SEED_SYMS;
      o_valid <= i_valid && !i_clear && (!i_en || seed_cnt_r == SEED_SYMS); // see RQ17
      o_two <= i_two;
      o_bits <= {b1 & i_two, b0};
    end
  end

  a_no_data_unseeded: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ17
    (i_en && seed_cnt_r < SEED_SYMS) |=> !o_valid)
    else $error("descrambler data before seeding");
  a_bypass_passes: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ13
    (i_valid && !i_en && !i_clear) |=> (o_valid && o_bits[0] == $past(i_bits[0])))
    else $error("bypass did not pass data");
endmodule

/* logic/dsssdm_sq.sv */
// Search and data mode signal quality integrator and drop-lock decision
`timescale 1ns/1ps
module dsssdm_sq (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Symbol measurements
  input wire logic i_run,
  input wire logic i_valid,
  input wire logic [15:0] i_amp,
  input wire logic [12:0] i_perr2,
  // Data-mode thresholds
  input wire logic [15:0] i_amp_thr,
  input wire logic [15:0] i_ph_thr,
  // Decision
  output logic o_drop,
  output logic [15:0] o_avg_amp,
  output logic [15:0] o_avg_pn
);
  import dsssdm_pkg::*;
  logic [6:0] cnt_r;
  logic [22:0] amp_acc_r, amp_sum;
  // Binary mode squares errors up to 4096, so 13 bits per symbol and 20 per block
  logic [19:0] pn_acc_r, pn_sum;
  logic [15:0] amp_avg, pn_avg;

  // Block sums including the current symbol
  always_comb begin
    amp_sum = amp_acc_r + {7'h00, i_amp};
    pn_sum = pn_acc_r + {7'h00, i_perr2};
    amp_avg = amp_sum[22:BLOCK_SHIFT];
    pn_avg = {3'h0, pn_sum[19:BLOCK_SHIFT]};
  end

  // Integrate over 128 symbols, decide once per block, then restart
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_run) begin
      cnt_r <= 7'h00;
      amp_acc_r <= 23'h000000;
      pn_acc_r <= 20'h00000;
      o_drop <= 1'b0;
    end else begin
      o_drop <= 1'b0;
      if (i_valid) begin
        cnt_r <= cnt_r + 7'h01; // see RQ3
        if (cnt_r == BLOCK_LAST) begin
          amp_acc_r <= 23'h000000; // see RQ19
          pn_acc_r <= 20'h00000;
          o_drop <= amp_avg < i_amp_thr || pn_avg > i_ph_thr; // see RQ5
        end else begin
          amp_acc_r <= amp_sum;
          pn_acc_r <= pn_sum;
        end
      end
    end
  end

  // Last block averages kept on o_avg_amp and o_avg_pn; no register reads them
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avg_amp <= 16'h0000;
      o_avg_pn <= 16'h0000;
    end else if (i_run && i_valid && cnt_r == BLOCK_LAST) begin
      o_avg_amp <= amp_avg;
      o_avg_pn <= pn_avg;
    end
  end

  a_drop_block_end: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ19
    o_drop |-> ($past(cnt_r) == BLOCK_LAST && $past(i_valid) && cnt_r == 7'h00))
    else $error("drop decided outside block end");
  a_drop_on_amp: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ5
    (i_run && i_valid && cnt_r == BLOCK_LAST && amp_avg < i_amp_thr) |=> o_drop)
    else $error("low amplitude did not drop lock");
endmodule

/* shared/dsssdm_pkg.sv */
// Shared constants and types for the spread-spectrum receive data path
package dsssdm_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] OFS_TEST_B = 8'h14;
  localparam logic [7:0] OFS_SEED = 8'h3C;
  localparam logic [7:0] OFS_TAP = 8'h40;
  localparam logic [7:0] OFS_AMP_HI = 8'h68;
  localparam logic [7:0] OFS_AMP_LO = 8'h6C;
  localparam logic [7:0] OFS_PH_HI = 8'h88;
  localparam logic [7:0] OFS_PH_LO = 8'h8C;
  localparam logic [7:0] OFS_TIMEOUT = 8'hA4;
  localparam logic [7:0] OFS_CTRL = 8'hF0;
  localparam logic [7:0] OFS_STATUS = 8'hF4;
  // Field positions
  localparam int unsigned ROT_INV_BIT = 7;
  localparam int unsigned CTRL_DESCR_EN_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_TEST_B = 8'h02;
  localparam logic [7:0] RST_SEED = 8'h00;
  localparam logic [7:0] RST_TAP = 8'h48;
  localparam logic [7:0] RST_AMP_HI = 8'h0F;
  localparam logic [7:0] RST_AMP_LO = 8'hFF;
  localparam logic [7:0] RST_PH_HI = 8'h09;
  localparam logic [7:0] RST_PH_LO = 8'h80;
  localparam logic [7:0] RST_TIMEOUT = 8'h90;
  localparam logic [7:0] RST_CTRL = 8'h01;
  // Symbol counts
  localparam logic [3:0] FREQ_LAST = 4'hF;
  localparam int unsigned FREQ_SHIFT = 4;
  localparam logic [6:0] BLOCK_LAST = 7'h7F;
  localparam int unsigned BLOCK_SHIFT = 7;
  localparam logic [2:0] SEED_SYMS = 3'h7;
  // Phase rounding offsets, 256 steps per turn
  localparam logic [7:0] QUAD_HALF = 8'h20;
  localparam logic [7:0] BIN_HALF = 8'h40;
  // Receive states, Gray coded along acquisition, search, data
  typedef enum logic [1:0] {
    ST_ACQ = 2'b00,
    ST_SFD = 2'b01,
    ST_DATA = 2'b11
  } dsssdm_state_e;
endpackage

/* verif/dsssdm_demod_tb.sv */
// Self-checking testbench for the receive data path
`timescale 1ns/1ps
module dsssdm_demod_tb;
  import dsssdm_pkg::*;
  // Clock, reset and counters
  logic clk = 1'b0;
  logic rst = 1'b1;
  int n_fail = 0;
  int comparisons = 0;
  // Stimulus
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sv = 1'b0;
  logic [7:0] sph = 8'h00;
  logic [7:0] ph_acc = 8'h00;
  logic [15:0] samp = 16'hFFFF;
  logic lock = 1'b0;
  logic qpsk = 1'b0;
  logic acq = 1'b0;
  logic sfd = 1'b0;
  // Outputs and values captured after each symbol
  logic [31:0] prdata;
  logic pready, pslverr, fvalid, rx_valid, rx_two, coh, drop, scr_en, rv, r2;
  int n_drop = 0;
  int n_fv = 0;
  logic [1:0] rx_bits, rb, np_last;
  logic [7:0] fcorr;
  logic [15:0] sq_var, np_count;
  logic [6:0] tx_seed, scr_tap;
  dsssdm_state_e state;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  // Pulse counters, looked at mid-cycle where registered pulses are settled
  always @(negedge clk) begin
    if (drop === 1'b1) begin
      n_drop++;
    end
    if (fvalid === 1'b1) begin
      n_fv++;
    end
  end

  dsssdm_demod dut_u (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sym_valid(sv), .i_sym_phase(sph), .i_sym_amp(samp),
    .i_nco_phase(8'h00), .i_pll_lock(lock), .i_qpsk(qpsk), .i_acq_done(acq),
    .i_sfd_found(sfd), .o_freq_corr(fcorr), .o_freq_valid(fvalid), .o_sq_var(sq_var),
    .o_rx_valid(rx_valid), .o_rx_two(rx_two), .o_rx_bits(rx_bits), .o_coherent(coh),
    .o_drop_lock(drop), .o_state(state), .o_tx_seed(tx_seed), .o_scr_tap(scr_tap),
    .o_scr_en(scr_en)
  );

  dsssdm_np_model np_u (
    .i_core_clk(clk), .i_rst(rst), .i_rx_valid(rx_valid), .i_rx_two(rx_two),
    .i_rx_bits(rx_bits), .o_count(np_count), .o_last(np_last)
  );

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request stands until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    check("register read", rd, exp);
  endtask

  // One symbol advancing the peak phase by a step; output sampled in the following cycle
  task automatic sym(input logic [7:0] step, input logic [15:0] amp);
    ph_acc = ph_acc + step;
    @(posedge clk);
    sv <= 1'b1;
    sph <= ph_acc;
    samp <= amp;
    @(posedge clk);
    sv <= 1'b0;
    @(negedge clk);
    rv = rx_valid;
    r2 = rx_two;
    rb = rx_bits;
  endtask

  task automatic ev(input logic to_search);
    @(posedge clk);
    acq <= to_search;
    sfd <= ~to_search;
    @(posedge clk);
    acq <= 1'b0;
    sfd <= 1'b0;
  endtask

  // Fresh reset, configuration, reference symbol, then delimiter search
  task automatic start(input logic [7:0] ctrl, input logic [7:0] tmo, input logic q);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    qpsk <= q;
    wr(OFS_CTRL, {24'h0, ctrl});
    wr(OFS_TIMEOUT, {24'h0, tmo});
    sym(8'h00, 16'hFFFF);
    check("output in acquisition", 32'(rv), 32'h0);
    ev(1'b1);
  endtask

  task automatic t_regs;
    logic [7:0] ofs [9] = '{OFS_TEST_B, OFS_SEED, OFS_TAP, OFS_AMP_HI, OFS_AMP_LO,
                            OFS_PH_HI, OFS_PH_LO, OFS_TIMEOUT, OFS_CTRL};
    logic [7:0] val [9] = '{8'h02, 8'h00, 8'h48, 8'h0F, 8'hFF, 8'h09, 8'h80, 8'h90, 8'h01};
    logic [31:0] rd;
    logic err;
    int i;
    for (i = 0; i < 9; i++) begin
      rdchk(ofs[i], {24'h0, val[i]});
    end
    apb(1'b0, 8'h44, 32'h0, rd, err);
    check("unmapped error", 32'(err), 32'h1);
    wr(OFS_SEED, 32'h55);
    wr(OFS_TAP, 32'h0C);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_AMP_HI, 32'h12);
    repeat (2) @(posedge clk);
    check("tx seed", 32'(tx_seed), 32'h55);
    check("scrambler taps", 32'(scr_tap), 32'h0C);
    check("scrambler enable", 32'(scr_en), 32'h0);
    rdchk(OFS_PH_HI, 32'h09);
    rdchk(OFS_AMP_HI, 32'h12);
  endtask

  task automatic t_map;
    logic [7:0] stp [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
    logic [1:0] exp [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    int i;
    start(8'h00, 8'hFF, 1'b1);
    for (i = 0; i < 4; i++) begin
      sym(stp[i], 16'hFFFF);
      check("dibit", 32'({rv, r2, rb}), 32'({2'b11, exp[i]}));
    end
    wr(OFS_TEST_B, 32'h82);
    sym(8'h40, 16'hFFFF);
    check("inverted dibit", 32'({rv, r2, rb}), 32'h0E);
    @(posedge clk);
    qpsk <= 1'b0;
    sym(8'h80, 16'hFFFF);
    check("binary one", 32'({rv, r2, rb}), 32'h09);
    sym(8'h00, 16'hFFFF);
    check("binary zero", 32'({rv, r2, rb}), 32'h08);
  endtask

  task automatic t_timer;
    int i, k;
    start(8'h00, 8'h04, 1'b0);
    lock <= 1'b1;
    for (i = 0; i < 3; i++) begin
      sym(8'h00, 16'hFFFF);
    end
    check("state in search", 32'(state), 32'(ST_SFD));
    check("coherent", 32'(coh), 32'h1);
    k = n_drop;
    sym(8'h00, 16'hFFFF);
    repeat (2) @(posedge clk);
    lock <= 1'b0;
    @(negedge clk);
    check("state after expiry", 32'(state), 32'(ST_ACQ));
    check("coherent in acquisition", 32'(coh), 32'h0);
    check("timeout drop", 32'(n_drop - k), 32'h1);
    ev(1'b1);
    sym(8'h00, 16'hFFFF);
    ev(1'b0);
    for (i = 0; i < 5; i++) begin
      sym(8'h00, 16'hFFFF);
    end
    check("state in data", 32'(state), 32'(ST_DATA));
  endtask

  // Low amplitude, then noisy phase, then both with limit thresholds
  task automatic t_quality;
    logic [15:0] amps [3] = '{16'h0100, 16'hFFFF, 16'h0100};
    logic [7:0] stp [3] = '{8'h00, 8'h32, 8'h32};
    int c, i, base, fv0;
    for (c = 0; c < 3; c++) begin
      start(8'h00, 8'hFF, 1'b0);
      ev(1'b0);
      if (c == 2) begin
        wr(OFS_AMP_HI, 32'h00);
        wr(OFS_AMP_LO, 32'h00);
        wr(OFS_PH_HI, 32'hFF);
        wr(OFS_PH_LO, 32'hFF);
      end
      base = n_drop;
      fv0 = n_fv;
      for (i = 0; i < 127; i++) begin
        sym(stp[c], amps[c]);
      end
      check("drop before block end", 32'(n_drop - base), 32'h0);
      sym(stp[c], amps[c]);
      // The drop pulse trails the deciding symbol by two cycles
      @(negedge clk);
      check("drop at block end", 32'(drop), (c == 2) ? 32'h0 : 32'h1);
      @(negedge clk);
      check("state after block", 32'(state), 32'((c == 2) ? ST_DATA : ST_ACQ));
      check("frequency updates", 32'(n_fv - fv0), 32'h8);
      check("frequency correction", 32'(fcorr), (c == 0) ? 32'h0 : 32'h32);
      check("phase variance", 32'(sq_var), 32'h0);
    end
  endtask

  task automatic t_descr;
    logic [14:0] data = 15'h4D6B;
    logic [6:0] sr = 7'h00;
    logic b;
    logic e;
    int i;
    start(8'h01, 8'hFF, 1'b0);
    for (i = 0; i < 15; i++) begin
      b = data[i];
      sym(b ? 8'h80 : 8'h00, 16'hFFFF);
      if (i < 7) begin
        check("seeding quiet", 32'(rv), 32'h0);
      end else begin
        e = b ^ (^(sr & 7'h48));
        check("descrambled", 32'({rv, rb[0]}), 32'({1'b1, e}));
      end
      sr = {sr[5:0], b};
    end
    @(negedge clk);
    check("symbols delivered", 32'(np_count), 32'h8);
    check("last bit kept", 32'(np_last), 32'(e));
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_map();
    t_timer();
    t_quality();
    t_descr();
    results();
  end
endmodule

/* verif/dsssdm_np_model.sv */
// Network processor model that collects received symbols
`timescale 1ns/1ps
module dsssdm_np_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Received data
  input wire logic i_rx_valid,
  input wire logic i_rx_two,
  input wire logic [1:0] i_rx_bits,
  // Collected results
  output logic [15:0] o_count,
  output logic [1:0] o_last
);
  // Never stalls: the receive path has no backpressure to offer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_count <= 16'h0000;
      o_last <= 2'h0;
    end else if (i_rx_valid) begin
      o_count <= o_count + 16'h0001;
      o_last <= i_rx_two ? i_rx_bits : {1'b0, i_rx_bits[0]};
    end
  end
endmodule
